//--- design/vcs_pkg.sv
/*
  Package for the video capture sync counters: register map, field positions,
  reset values, capture mode codes and embedded timing code constants.
  Assumes a single 100 MHz system clock domain; the pixel clock is sampled.
*/
`default_nettype none

package vcs_pkg;

  // ------------------------------------------------------------------
  // Register word indices (plain register port, 4-bit address)
  // ------------------------------------------------------------------
  localparam logic [3:0] CTRL_ADDR = 4'h0;     // channel_control_reg
  localparam logic [3:0] WIN_ADDR = 4'h1;      // window start/stop lines
  localparam logic [3:0] STAT_ADDR = 4'h2;     // done flags, write 1 to clear
  localparam logic [3:0] COUNT_ADDR = 4'h3;    // live counters, read only

  // ------------------------------------------------------------------
  // Control field positions
  // ------------------------------------------------------------------
  localparam int CF1_BIT = 0;   // first_field_capture_bit
  localparam int CF2_BIT = 1;   // second_field_capture_bit
  localparam int WHOLE_BIT = 2; // whole_picture_bit
  localparam int REP_BIT = 3;   // repeat_capture_bit
  localparam int EXT_BIT = 4;   // external_sync_select
  localparam int LRST_BIT = 5;  // line_reset_point_select
  localparam int SRST_BIT = 6;  // sample_reset_point_select
  localparam int BT_BIT = 7;    // 1 = BT.656 (two edges per sample), 0 = Y/C
  localparam int HPIN_BIT = 8;  // horiz_control_pin used as horizontal control
  localparam int VPIN_BIT = 9;  // vert_control_pin used as vertical control
  localparam int CHB_BIT = 10;  // a second channel is in use
  localparam int CTRL_W = 11;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h040; // sample reset at SAV

  // Status bit positions
  localparam int F2DONE_BIT = 0;
  localparam int PICDONE_BIT = 1;
  localparam int CDONE_BIT = 2;
  localparam int FIELD_BIT = 3;
  localparam int INWIN_BIT = 4;

  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] START_RESET = 12'h001;
  localparam logic [CNT_W-1:0] STOP_RESET = 12'h0F0;

  // Capture modes {repeat, whole, field2, field1}
  localparam logic [3:0] MODE_CONT_F2 = 4'h a;
  localparam logic [3:0] MODE_CONT_FRAME = 4'h c;
  localparam logic [3:0] MODE_CONT_PROG = 4'h d;

  // Embedded timing code: FF 00 00 XY, XY bits F=6 V=5 H=4
  localparam logic [7:0] CODE_FF = 8'hff;
  localparam logic [7:0] CODE_00 = 8'h00;
  localparam int F_BIT = 6;
  localparam int V_BIT = 5;
  localparam int H_BIT = 4;

endpackage : vcs_pkg

`default_nettype wire

//--- design/vcs_sync_counters.sv
/*
  Video capture sync counters: sample and line counters with selectable reset
  points (embedded codes or external pins) and continuous capture completion.
  Assumes pixel clock, pixel data and control pins come from the decoder,
  asynchronous to clk; all of them are sampled by clk (pixel clock <= clk/4).
*/
`default_nettype none

module vcs_sync_counters (
  // System
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Decoder pins
  input wire logic pixelClockIn,
  input wire logic [7:0] pixelData,
  input wire logic horizControlPin,
  input wire logic vertControlPin,
  input wire logic captureGate,
  // Status outputs
  output logic captureDone,
  output logic inWindow
);

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [vcs_pkg::CTRL_W-1:0] ctrl_r;          // channel_control_reg
  logic [vcs_pkg::CNT_W-1:0] winStart_r;       // window_start_line
  logic [vcs_pkg::CNT_W-1:0] winStop_r;        // window stop line
  logic doneMask_r;                            // gates captureDone output
  logic f2Done_r;                              // second_field_done_flag
  logic picDone_r;                             // picture_done_flag
  logic capDone_r;                             // capture_done_status
  logic [vcs_pkg::CNT_W-1:0] lineCnt_r;        // line_counter
  logic [vcs_pkg::CNT_W-1:0] sampleCnt_r;      // sample_counter
  logic field2_r;                              // current field is field 2

  // Decoded control
  logic [3:0] capMode;
  logic extSel;
  logic pinVert;
  assign capMode = ctrl_r[vcs_pkg::REP_BIT:vcs_pkg::CF1_BIT];
  assign extSel = ctrl_r[vcs_pkg::EXT_BIT];
  // Pin vertical sync only allowed with a single channel
  assign pinVert = extSel && !ctrl_r[vcs_pkg::CHB_BIT];

  // ------------------------------------------------------------------
  // Pin synchronisers: three stages, change counts when 2nd and 3rd agree
  // ------------------------------------------------------------------
  logic [11:0] pinAsync;
  logic [11:0] pinS1_r;
  logic [11:0] pinS2_r;
  logic [11:0] pinS3_r;
  logic [11:0] pinStable_r;
  logic [11:0] pinPrev_r;
  assign pinAsync = {captureGate, vertControlPin, horizControlPin, pixelClockIn, pixelData};

  // Synchroniser chain; first stage feeds only the second
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pinS1_r <= 12'h000;
      pinS2_r <= 12'h000;
      pinS3_r <= 12'h000;
    end else if (clkEn) begin
      pinS1_r <= pinAsync;
      pinS2_r <= pinS1_r;
      pinS3_r <= pinS2_r;
    end
  end

  // Filtered value moves only where the last two stages agree
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pinStable_r <= 12'h000;
      pinPrev_r <= 12'h000;
    end else if (clkEn) begin
      pinStable_r <= (pinS2_r & pinS3_r) | (pinStable_r & (pinS2_r ^ pinS3_r));
      pinPrev_r <= pinStable_r;
    end
  end

  // Pixel clock edge and pin edges (active edge = rising)
  logic pixEdge;
  logic hActEdge;
  logic hInactEdge;
  logic vActEdge;
  logic vInactEdge;
  logic gateOn;
  logic [7:0] pixByte;
  assign pixEdge = pinStable_r[8] && !pinPrev_r[8];
  assign hActEdge = pinStable_r[9] && !pinPrev_r[9];
  assign hInactEdge = !pinStable_r[9] && pinPrev_r[9];
  assign vActEdge = pinStable_r[10] && !pinPrev_r[10];
  assign vInactEdge = !pinStable_r[10] && pinPrev_r[10];
  assign pixByte = pinStable_r[7:0];
  // No external gate exists when the horizontal pin is a control input
  assign gateOn = ctrl_r[vcs_pkg::HPIN_BIT] || pinStable_r[11];

  // ------------------------------------------------------------------
  // Embedded timing code detector (FF 00 00 XY on pixel edges)
  // ------------------------------------------------------------------
  logic [23:0] codeHist_r;
  logic codeSeen;
  logic isEav;
  logic isSav;
  assign codeSeen = pixEdge && (codeHist_r == {vcs_pkg::CODE_FF, vcs_pkg::CODE_00,
                                               vcs_pkg::CODE_00});
  assign isEav = codeSeen && pixByte[vcs_pkg::H_BIT];
  assign isSav = codeSeen && !pixByte[vcs_pkg::H_BIT];

  // Keep the last three bytes seen on pixel edges
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      codeHist_r <= 24'h00_0000;
    end else if (clkEn && pixEdge) begin
      codeHist_r <= {codeHist_r[15:0], pixByte};
    end
  end

  // ------------------------------------------------------------------
  // Sample counter
  // ------------------------------------------------------------------
  logic sampleRst;
  logic phase_r;    // BT.656 carries one sample per two edges
  // Reset event picked by external select and sample reset select
  always_comb begin
    unique case ({extSel, ctrl_r[vcs_pkg::SRST_BIT]})
      2'b00: sampleRst = isEav;
      2'b01: sampleRst = isSav;
      2'b10: sampleRst = hActEdge;
      2'b11: sampleRst = hInactEdge;
    endcase
  end

  // Advances only on pixel edges with the gate active
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sampleCnt_r <= '0;
      phase_r <= 1'b0;
    end else if (clkEn) begin
      if (sampleRst) begin
        sampleCnt_r <= '0;
        phase_r <= 1'b0;
      end else if (pixEdge && gateOn) begin
        phase_r <= ~phase_r;
        if (!ctrl_r[vcs_pkg::BT_BIT] || phase_r) begin
          sampleCnt_r <= sampleCnt_r + 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Line counter
  // ------------------------------------------------------------------
  logic lastV_r;      // V bit of previous EAV
  logic vArmed_r;     // pin edge seen, waiting for sample reset
  logic lineRst;
  logic lineInc;
  logic fieldEnd;     // line reset marks a new field

  // Embedded: reset on V transition at EAV; pin: first sample reset after edge
  always_comb begin
    lineRst = 1'b0;
    lineInc = 1'b0;
    if (!extSel) begin
      lineInc = isEav;
      if (!ctrl_r[vcs_pkg::LRST_BIT]) begin
        lineRst = isEav && pixByte[vcs_pkg::V_BIT] && !lastV_r;
      end else begin
        lineRst = isEav && !pixByte[vcs_pkg::V_BIT] && lastV_r;
      end
    end else if (pinVert) begin
      lineInc = sampleRst;
      lineRst = sampleRst && vArmed_r;
    end
  end
  assign fieldEnd = lineRst;

  // Remember the previous V bit and arm on the selected vertical edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lastV_r <= 1'b0;
      vArmed_r <= 1'b0;
    end else if (clkEn) begin
      if (isEav) begin
        lastV_r <= pixByte[vcs_pkg::V_BIT];
      end
      if (lineRst) begin
        vArmed_r <= 1'b0;
      end else if (ctrl_r[vcs_pkg::VPIN_BIT] &&
                   (ctrl_r[vcs_pkg::LRST_BIT] ? vInactEdge : vActEdge)) begin
        vArmed_r <= 1'b1;
      end
    end
  end

  // Count lines; line reset loads 1 so the first line is numbered one
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lineCnt_r <= '0;
    end else if (clkEn) begin
      if (lineRst) begin
        lineCnt_r <= vcs_pkg::START_RESET;
      end else if (lineInc) begin
        lineCnt_r <= lineCnt_r + 1'b1;
      end
    end
  end

  // Field tracking from F bit in embedded mode, alternation in pin mode
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      field2_r <= 1'b0;
    end else if (clkEn && fieldEnd) begin
      field2_r <= extSel ? ~field2_r : pixByte[vcs_pkg::F_BIT];
    end
  end

  // ------------------------------------------------------------------
  // Window compare and capture completion
  // ------------------------------------------------------------------
  logic winNow;
  logic wantF1;
  logic wantF2;
  // Window compare on the current line number, start line one allowed
  assign winNow = (lineCnt_r >= winStart_r) && (lineCnt_r <= winStop_r);

  // Which fields the mode captures
  always_comb begin
    wantF1 = 1'b0;
    wantF2 = 1'b0;
    unique case (capMode)
      vcs_pkg::MODE_CONT_F2: wantF2 = 1'b1;
      vcs_pkg::MODE_CONT_FRAME: begin
        wantF1 = 1'b1;
        wantF2 = 1'b1;
      end
      vcs_pkg::MODE_CONT_PROG: wantF1 = 1'b1;
      default: ;                 // Other codes are outside this block
    endcase
  end

  // Field completion sets flags; set wins over software clear
  logic f1Fin;
  logic f2Fin;
  logic clrWr;
  assign f1Fin = fieldEnd && !field2_r && wantF1;
  assign f2Fin = fieldEnd && field2_r && wantF2;
  assign clrWr = regWr && (regAddr == vcs_pkg::STAT_ADDR);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      f2Done_r <= 1'b0;
      picDone_r <= 1'b0;
      capDone_r <= 1'b0;
    end else if (clkEn) begin
      if (f2Fin && capMode == vcs_pkg::MODE_CONT_F2) begin
        f2Done_r <= 1'b1;
      end else if (clrWr && regWdata[vcs_pkg::F2DONE_BIT]) begin
        f2Done_r <= 1'b0;
      end
      if ((f2Fin && capMode == vcs_pkg::MODE_CONT_FRAME) ||
          (f1Fin && capMode == vcs_pkg::MODE_CONT_PROG)) begin
        picDone_r <= 1'b1;
      end else if (clrWr && regWdata[vcs_pkg::PICDONE_BIT]) begin
        picDone_r <= 1'b0;
      end
      // Frame mode completes only after field 2, progressive after field 1
      if ((f2Fin && capMode != vcs_pkg::MODE_CONT_PROG) ||
          (f1Fin && capMode == vcs_pkg::MODE_CONT_PROG)) begin
        capDone_r <= 1'b1;
      end else if (clrWr && regWdata[vcs_pkg::CDONE_BIT]) begin
        capDone_r <= 1'b0;
      end
    end
  end

  // Outputs: mask gates only the indication, capture keeps running
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      captureDone <= 1'b0;
      inWindow <= 1'b0;
    end else if (clkEn) begin
      captureDone <= capDone_r && !doneMask_r;
      inWindow <= winNow && ((field2_r && wantF2) || (!field2_r && wantF1));
    end
  end

  // ------------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= vcs_pkg::CTRL_RESET;
      winStart_r <= vcs_pkg::START_RESET;
      winStop_r <= vcs_pkg::STOP_RESET;
      doneMask_r <= 1'b0;
    end else if (clkEn && regWr) begin
      if (regAddr == vcs_pkg::CTRL_ADDR) begin
        ctrl_r <= regWdata[vcs_pkg::CTRL_W-1:0];
        doneMask_r <= regWdata[31];
      end else if (regAddr == vcs_pkg::WIN_ADDR) begin
        winStart_r <= regWdata[vcs_pkg::CNT_W-1:0];
        winStop_r <= regWdata[16 +: vcs_pkg::CNT_W];
      end
    end
  end

  // Register reads, data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdata <= 32'h0000_0000;
    end else if (clkEn) begin
      regRdata <= 32'h0000_0000;
      if (regRd) begin
        unique case (regAddr)
          vcs_pkg::CTRL_ADDR: regRdata <= {doneMask_r, 20'h0_0000, ctrl_r};
          vcs_pkg::WIN_ADDR: regRdata <= {4'h0, winStop_r, 4'h0, winStart_r};
          vcs_pkg::STAT_ADDR: regRdata <= {27'h000_0000, winNow, field2_r,
                                           capDone_r, picDone_r, f2Done_r};
          vcs_pkg::COUNT_ADDR: regRdata <= {4'h0, lineCnt_r, 4'h0, sampleCnt_r};
          default: regRdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // vcs_sync_counters

`default_nettype wire

//--- tb/vcs_sync_counters_props.sv
/*
  Port checker for the sync counters.
  Assumes it is bound to vcs_sync_counters and sees only its ports.
*/
`default_nettype none

module vcs_sync_counters_props (
  // System
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  // Status
  input wire logic captureDone,
  input wire logic inWindow
);
  // ----------------
  // Shadow registers
  // ----------------
  logic [31:0] ctrlR; // Control word as software wrote it
  logic [31:0] winR; // Window lines as written
  logic rdGo; // Read taken at this edge
  logic modeOn; // A continuous capture mode is chosen
  assign rdGo = regRd && clkEn;
  assign modeOn = ctrlR[3:0] inside {vcs_pkg::MODE_CONT_F2, vcs_pkg::MODE_CONT_FRAME,
    vcs_pkg::MODE_CONT_PROG};

  // Track writes; unmapped bits are dropped so compares stay exact
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrlR <= {21'h0_0000, vcs_pkg::CTRL_RESET};
      winR <= {4'h0, vcs_pkg::STOP_RESET, 4'h0, vcs_pkg::START_RESET};
    end else if (regWr && clkEn && regAddr == vcs_pkg::CTRL_ADDR) begin
      ctrlR <= regWdata & 32'h8000_07ff;
    end else if (regWr && clkEn && regAddr == vcs_pkg::WIN_ADDR) begin
      winR <= regWdata & 32'h0fff_0fff;
    end
  end

  // ----------
  // Properties
  // ----------
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_reset_quiet:
  assert property ($past(sys_rst) |-> regRdata == 32'h0 && !captureDone && !inWindow)
    else $error("outputs not quiet after reset");
  a_rdata_one_cycle:
  assert property ($past(clkEn) && !$past(regRd) |-> regRdata == 32'h0)
    else $error("read data outside its cycle");
  a_unmapped_zero:
  assert property (rdGo && regAddr > 4'h3 |=> regRdata == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_readback:
  assert property (rdGo && regAddr == vcs_pkg::CTRL_ADDR |=> regRdata == $past(ctrlR))
    else $error("control read back wrong");
  a_win_readback:
  assert property (rdGo && regAddr == vcs_pkg::WIN_ADDR |=> regRdata == $past(winR))
    else $error("window read back wrong");
  a_done_raw_match:
  assert property (rdGo && regAddr == vcs_pkg::STAT_ADDR && !ctrlR[31]
    |=> regRdata[vcs_pkg::CDONE_BIT] == captureDone)
    else $error("done output differs from status");
  a_mask_holds_done:
  assert property (ctrlR[31] && $past(ctrlR[31]) |-> !captureDone)
    else $error("masked done reached output");
  a_freeze_outputs:
  assert property (!clkEn |=> $stable(regRdata) && $stable(captureDone) && $stable(inWindow))
    else $error("outputs moved while frozen");
  a_window_idle:
  assert property (!modeOn && !$past(modeOn) && !$past(modeOn, 2) |-> !inWindow)
    else $error("window flag without capture");
endmodule // vcs_sync_counters_props

bind vcs_sync_counters vcs_sync_counters_props vcs_sync_counters_props_i (
  .clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .captureDone(captureDone),
  .inWindow(inWindow));

`default_nettype wire

//--- tb/vcs_decoder_model.sv
/*
  Behavioural video decoder: sample stream, timing codes and sync pins.
  Assumes a 160 ns pixel clock that runs only while samples are sent.
*/
`default_nettype none

module vcs_decoder_model (
  // Link
  output logic pixelClockIn,
  output logic [7:0] pixelData,
  // Sync pins
  output logic horizControlPin,
  output logic vertControlPin
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle link: clock parked low, pins inactive
  initial begin
    pixelClockIn = 1'b0;
    pixelData = 8'h00;
    horizControlPin = 1'b0;
    vertControlPin = 1'b0;
  end

  // One sample; data is spoiled after the edge so stale holds are not trusted
  task automatic sendSample(input logic [7:0] b);
    pixelData = b;
    #80 pixelClockIn = 1'b1;
    #80 pixelClockIn = 1'b0;
    pixelData = ~b;
  endtask

  // Timing code: preamble then status word with protection bits
  task automatic sendCode(input logic f, input logic v, input logic h);
    sendSample(vcs_pkg::CODE_FF);
    sendSample(vcs_pkg::CODE_00);
    sendSample(vcs_pkg::CODE_00);
    sendSample({1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h});
  endtask

  // Active video samples, kept clear of the code values
  task automatic sendPixels(input int n);
    repeat (n) sendSample(8'h80);
  endtask

  // Sync pin levels
  task automatic setPins(input logic h, input logic v);
    horizControlPin = h;
    vertControlPin = v;
    #100;
  endtask
endmodule // vcs_decoder_model

`default_nettype wire

//--- tb/vcs_sync_counters_test.sv
/*
  Self-checking bench for the sync counters.
  Assumes the checker is bound in and the decoder model drives the link.
*/
`default_nettype none

module vcs_sync_counters_test;
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------
  // Signals and state
  // ------------------
  logic clk, sys_rst, clkEn, regWr, regRd, captureGate, rdPend;
  logic [3:0] regAddr;
  logic [31:0] regWdata, regRdata, rnd;
  logic pixelClockIn, horizControlPin, vertControlPin, captureDone, inWindow;
  logic [7:0] pixelData;
  logic [11:0] winStop; // Stop line the window was last given, start is one
  logic [31:0] expQ[$]; // Expected read data, oldest first
  int errTotal, checkCount, cycles, seed, n;

  vcs_sync_counters vcs_sync_counters_i (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .pixelClockIn(pixelClockIn), .pixelData(pixelData),
    .horizControlPin(horizControlPin), .vertControlPin(vertControlPin),
    .captureGate(captureGate), .captureDone(captureDone), .inWindow(inWindow));
  vcs_decoder_model vcs_decoder_model_i (.pixelClockIn(pixelClockIn), .pixelData(pixelData),
    .horizControlPin(horizControlPin), .vertControlPin(vertControlPin));

  always #5 clk = ~clk;

  // ---------------
  // Helper tasks
  // ---------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errTotal++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrReg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // Read request; the expected word waits in the queue for the monitor
  task automatic rdReg(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    expQ.push_back(e);
    @(posedge clk);
    regRd <= 1'b0;
  endtask

  // Pin and pixel edges need the input synchronisers to settle
  task automatic settle();
    repeat (12) @(posedge clk);
  endtask

  function automatic logic [31:0] cnt(input logic [11:0] l, input logic [11:0] s);
    return {4'h0, l, 4'h0, s};
  endfunction

  // Status word: flags {field2, done, picture, field2 done} and window test of line l
  function automatic logic [31:0] stat(input logic [3:0] f, input logic [11:0] l);
    return {27'h000_0000, (l >= 12'h001) && (l <= winStop), f};
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Monitor: read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rdPend) check(regRdata, expQ.pop_front());
    rdPend <= regRd && clkEn;
  end

  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      errTotal++;
      print_verdict();
    end
  end

  // -------------
  // Main sequence
  // -------------
  initial begin
    {clk, sys_rst, clkEn, regWr, regRd, rdPend, captureGate} = 7'b0110001;
    {regAddr, regWdata, errTotal, checkCount, cycles} = '0;
    seed = 4968;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    // Reset values, unmapped place, window start of one
    rdReg(vcs_pkg::CTRL_ADDR, 32'h0000_0040);
    rdReg(vcs_pkg::WIN_ADDR, 32'h00f0_0001);
    rdReg(vcs_pkg::COUNT_ADDR, 32'h0000_0000);
    rnd = $random(seed);
    wrReg(4'hf, rnd);
    rdReg(4'hf, 32'h0000_0000);
    wrReg(vcs_pkg::WIN_ADDR, {4'h0, rnd[27:16], 16'h0001});
    winStop = rnd[27:16];
    rdReg(vcs_pkg::WIN_ADDR, {4'h0, rnd[27:16], 16'h0001});
    $display("test registers done");
    // Sample reset at SAV, gate and two-edge counting; only legal modes
    wrReg(vcs_pkg::CTRL_ADDR, 32'h0000_004c);
    vcs_decoder_model_i.sendCode(1'b0, 1'b0, 1'b0);
    n = 2 + ($unsigned($random(seed)) % 8);
    vcs_decoder_model_i.sendPixels(n);
    settle();
    rdReg(vcs_pkg::COUNT_ADDR, cnt(12'h000, 12'(n)));
    @(posedge clk) captureGate <= 1'b0;
    vcs_decoder_model_i.sendPixels(3);
    settle();
    rdReg(vcs_pkg::COUNT_ADDR, cnt(12'h000, 12'(n)));
    @(posedge clk) captureGate <= 1'b1;
    wrReg(vcs_pkg::CTRL_ADDR, 32'h0000_00cc);
    vcs_decoder_model_i.sendCode(1'b0, 1'b0, 1'b0);
    vcs_decoder_model_i.sendPixels(6);
    settle();
    rdReg(vcs_pkg::COUNT_ADDR, cnt(12'h000, 12'h003));
    $display("test sample counter done");
    // EAV sample reset, line reset at blanking start then at first active line
    wrReg(vcs_pkg::CTRL_ADDR, 32'h0000_000c);
    vcs_decoder_model_i.sendCode(1'b0, 1'b0, 1'b1);
    vcs_decoder_model_i.sendPixels(4);
    settle();
    rdReg(vcs_pkg::COUNT_ADDR, cnt(12'h001, 12'h004));
    vcs_decoder_model_i.sendCode(1'b1, 1'b1, 1'b1);
    vcs_decoder_model_i.sendCode(1'b1, 1'b1, 1'b1);
    vcs_decoder_model_i.sendCode(1'b1, 1'b0, 1'b1);
    settle();
    rdReg(vcs_pkg::COUNT_ADDR, cnt(12'h003, 12'h000));
    rdReg(vcs_pkg::STAT_ADDR, stat(4'b1000, 12'h003));
    wrReg(vcs_pkg::CTRL_ADDR, 32'h8000_002c);
    vcs_decoder_model_i.sendCode(1'b0, 1'b1, 1'b1);
    settle();
    rdReg(vcs_pkg::COUNT_ADDR, cnt(12'h004, 12'h000));
    vcs_decoder_model_i.sendCode(1'b0, 1'b0, 1'b1);
    vcs_decoder_model_i.sendCode(1'b0, 1'b0, 1'b1);
    settle();
    rdReg(vcs_pkg::COUNT_ADDR, cnt(12'h002, 12'h000));
    rdReg(vcs_pkg::STAT_ADDR, stat(4'b0110, 12'h002));
    @(negedge clk) check(captureDone, 1'b0);
    wrReg(vcs_pkg::CTRL_ADDR, 32'h0000_002c);
    rdReg(vcs_pkg::CTRL_ADDR, 32'h0000_002c);
    @(negedge clk) check(captureDone, 1'b1);
    $display("test embedded codes done");
    // Continuous field 2: a field 1 end leaves the flags alone
    wrReg(vcs_pkg::STAT_ADDR, 32'h0000_0007);
    wrReg(vcs_pkg::CTRL_ADDR, 32'h0000_002a);
    vcs_decoder_model_i.sendCode(1'b1, 1'b1, 1'b1);
    vcs_decoder_model_i.sendCode(1'b1, 1'b0, 1'b1);
    settle();
    rdReg(vcs_pkg::STAT_ADDR, stat(4'b1000, 12'h001));
    vcs_decoder_model_i.sendCode(1'b0, 1'b1, 1'b1);
    vcs_decoder_model_i.sendCode(1'b0, 1'b0, 1'b1);
    settle();
    rdReg(vcs_pkg::STAT_ADDR, stat(4'b0101, 12'h001));
    // Continuous progressive: picture flag after field 1, window of lines one to two
    wrReg(vcs_pkg::STAT_ADDR, 32'h0000_0007);
    wrReg(vcs_pkg::CTRL_ADDR, 32'h0000_002d);
    wrReg(vcs_pkg::WIN_ADDR, 32'h0002_0001);
    winStop = 12'h002;
    vcs_decoder_model_i.sendCode(1'b0, 1'b1, 1'b1);
    vcs_decoder_model_i.sendCode(1'b0, 1'b0, 1'b1);
    settle();
    rdReg(vcs_pkg::STAT_ADDR, stat(4'b0110, 12'h001));
    @(negedge clk) check(inWindow, 1'b1);
    check(captureDone, 1'b1);
    vcs_decoder_model_i.sendCode(1'b0, 1'b0, 1'b1);
    vcs_decoder_model_i.sendCode(1'b0, 1'b0, 1'b1);
    settle();
    @(negedge clk) check(inWindow, 1'b0);
    $display("test capture modes done");
    // Pin modes; gate held low to show it is ignored under horizontal control
    wrReg(vcs_pkg::CTRL_ADDR, 32'h0000_031c);
    @(posedge clk) captureGate <= 1'b0;
    vcs_decoder_model_i.setPins(1'b0, 1'b1);
    vcs_decoder_model_i.setPins(1'b1, 1'b1);
    vcs_decoder_model_i.sendPixels(5);
    settle();
    rdReg(vcs_pkg::COUNT_ADDR, cnt(12'h001, 12'h005));
    vcs_decoder_model_i.setPins(1'b0, 1'b1);
    vcs_decoder_model_i.setPins(1'b1, 1'b1);
    settle();
    rdReg(vcs_pkg::COUNT_ADDR, cnt(12'h002, 12'h000));
    wrReg(vcs_pkg::CTRL_ADDR, 32'h0000_033c);
    vcs_decoder_model_i.setPins(1'b0, 1'b0);
    vcs_decoder_model_i.setPins(1'b1, 1'b0);
    vcs_decoder_model_i.sendPixels(3);
    settle();
    rdReg(vcs_pkg::COUNT_ADDR, cnt(12'h001, 12'h003));
    wrReg(vcs_pkg::CTRL_ADDR, 32'h0000_037c);
    vcs_decoder_model_i.setPins(1'b0, 1'b0);
    settle();
    rdReg(vcs_pkg::COUNT_ADDR, cnt(12'h002, 12'h000));
    // Second channel in use: pin line modes are off, line count stays
    wrReg(vcs_pkg::CTRL_ADDR, 32'h0000_077c);
    vcs_decoder_model_i.setPins(1'b1, 1'b0);
    vcs_decoder_model_i.setPins(1'b0, 1'b0);
    settle();
    rdReg(vcs_pkg::COUNT_ADDR, cnt(12'h002, 12'h000));
    @(posedge clk) clkEn <= 1'b0;
    repeat (3) @(posedge clk);
    clkEn <= 1'b1;
    $display("test pin sync done");
    repeat (3) @(posedge clk);
    print_verdict();
  end
endmodule // vcs_sync_counters_test

`default_nettype wire
